// *** rtl/wakeup_timer_pkg.sv ***
package wakeup_timer_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0]  IDX_CONTROL      = 10'h023;
	localparam logic [9:0]  IDX_RELOAD_HIGH  = 10'h024;
	localparam logic [9:0]  IDX_RELOAD_LOW   = 10'h025;
	localparam logic [9:0]  IDX_COUNT_HIGH   = 10'h026;
	localparam logic [9:0]  IDX_COUNT_LOW    = 10'h027;
	localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h030;
	localparam logic [9:0]  IDX_IRQ_MASK     = 10'h031;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int          CTL_ACTIVE_BIT   = 7;
	localparam int          CTL_PERMIT_BIT   = 6;
	localparam int          CTL_TRIM_BIT     = 5;
	localparam int          CTL_CARD_BIT     = 4;
	localparam int          CTL_RELOAD_BIT   = 3;
	localparam int          CTL_WAKE_BIT     = 2;
	localparam int          CTL_SEL_LSB      = 0;

	// ----------------------------------------------------------------
	// interrupt status fields
	// ----------------------------------------------------------------
	localparam int          ST_UNDERFLOW_BIT = 0;
	localparam int          ST_CARD_BIT      = 1;
	localparam int          ST_NOCARD_BIT    = 2;
	localparam int          ST_WIDTH         = 3;

	// ----------------------------------------------------------------
	// reset values and tick dividers
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTL_RESET        = 8'h00;
	localparam logic [7:0]  RELOAD_RESET     = 8'h00;
	localparam logic [15:0] COUNT_RESET      = 16'h0000;
	localparam logic [2:0]  MASK_RESET       = 3'h0;
	localparam logic [5:0]  DIV_BY_8         = 6'h08;
	localparam logic [5:0]  DIV_BY_16        = 6'h10;
	localparam logic [5:0]  DIV_BY_32        = 6'h20;

	// card detection sequencer
	typedef enum logic {
		CD_IDLE,
		CD_WINDOW
	} card_state_e;

endpackage : wakeup_timer_pkg

// *** rtl/wake_tick_if.sv ***
`timescale 1ns/1ps
// tick source select goes out, one-cycle tick comes back
interface wake_tick_if;
	logic       tick;
	logic [1:0] sel;
	modport source (input sel, output tick);
	modport sink   (output sel, input tick);
endinterface : wake_tick_if

// *** rtl/wake_tick_gen.sv ***
`timescale 1ns/1ps
module wake_tick_gen
	import wakeup_timer_pkg::*;
(
	// clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// oscillator pin
	input  wire logic   lfo_clk_pin,
	// tick towards the counter
	wake_tick_if.source tick_bus
);

	// all state of the tick generator
	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       last;
		logic [5:0] pre;
		logic       tick;
	} tick_state_s;

	tick_state_s q;
	tick_state_s d;

	// ----------------------------------------------------------------
	// divider decode
	// ----------------------------------------------------------------
	function automatic logic [5:0] div_of(input logic [1:0] sel);
		unique case (sel)
			2'h1: div_of = DIV_BY_8;
			2'h2: div_of = DIV_BY_16;
			2'h3: div_of = DIV_BY_32;
			default: div_of = 6'h01;
		endcase
	endfunction : div_of

	// ----------------------------------------------------------------
	// synchronise, detect rising edge, divide
	// ----------------------------------------------------------------
	always_comb begin
		d       = q;
		d.sync1 = lfo_clk_pin;
		d.sync2 = q.sync1;
		d.last  = q.sync2;
		d.tick  = 1'b0;
		// count oscillator edges, tick once per division
		if (q.sync2 && !q.last) begin
			if (q.pre >= div_of(tick_bus.sel) - 6'h01) begin
				d.pre  = 6'h00;
				d.tick = 1'b1;
			end else begin
				d.pre = q.pre + 6'h01;
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_bus.tick = q.tick;

endmodule : wake_tick_gen

// *** rtl/wakeup_timer_low_power_card_detect.sv ***
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module wakeup_timer_low_power_card_detect
	import wakeup_timer_pkg::*;
(
	// clock and reset
	input  wire  logic        pclk,
	input  wire  logic        presetn,
	// apb slave
	input  wire  logic [11:0] paddr,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [31:0] pwdata,
	output logic        [31:0] prdata,
	output logic              pready,
	output logic              pslverr,
	// oscillator pin
	input  wire  logic        lfo_clk_pin,
	// partner blocks
	input  wire  logic        trim_done,
	input  wire  logic        rf_window_done,
	input  wire  logic        card_found,
	// events and controls out
	output logic              irq,
	output logic              wake_req,
	output logic              trim_start,
	output logic              rf_window_start,
	output logic              rf_field_en,
	output logic              power_down_req
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------

	// all state of the timer
	typedef struct packed {
		logic                timer_active_flag;
		logic                underflow_trim_enable;
		logic                underflow_card_detect_enable;
		logic                reload_on_zero;
		logic                wake_on_underflow;
		logic [1:0]          tick_source_select;
		logic [7:0]          wake_reload_high;
		logic [7:0]          wake_reload_low;
		logic [15:0]         count;
		logic [ST_WIDTH-1:0] status;
		logic [ST_WIDTH-1:0] mask;
		card_state_e         card_state;
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
		logic                irq;
		logic                wake_req;
		logic                trim_start;
		logic                rf_window_start;
		logic                rf_field_en;
		logic                power_down_req;
	} timer_state_s;

	timer_state_s        q;               // registered state
	timer_state_s        d;               // next state
	logic                underflow;       // tick arrived at zero
	logic                wr_access;       // write completes this edge
	logic                wr_ctl;          // control register written
	logic [15:0]         wake_reload_word;
	logic [ST_WIDTH-1:0] st_set;          // hardware sets
	logic [ST_WIDTH-1:0] st_clr;          // software clears

	wake_tick_if tick_bus ();

	// ----------------------------------------------------------------
	// tick source
	// ----------------------------------------------------------------

	// divided oscillator ticks
	wake_tick_gen u_tick (
		.pclk        (pclk),
		.presetn     (presetn),
		.lfo_clk_pin (lfo_clk_pin),
		.tick_bus    (tick_bus)
	);

	assign tick_bus.sel = q.tick_source_select;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------

	// word index of an aligned address, all-ones when misaligned
	function automatic logic [9:0] word_index(input logic [11:0] addr);
		word_index = (addr[1:0] == 2'h0) ? addr[11:2] : 10'h3FF;
	endfunction : word_index

	// true for every implemented register
	function automatic logic is_mapped(input logic [11:0] addr);
		unique case (word_index(addr))
			IDX_CONTROL, IDX_RELOAD_HIGH, IDX_RELOAD_LOW,
			IDX_COUNT_HIGH, IDX_COUNT_LOW,
			IDX_IRQ_STATUS, IDX_IRQ_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------

	// reload word from the two bytes
	assign wake_reload_word = {q.wake_reload_high, q.wake_reload_low};
	// access phase with ready ends a transfer
	assign wr_access = psel && penable && q.pready && pwrite && !q.pslverr;
	assign wr_ctl    = wr_access && (word_index(paddr) == IDX_CONTROL);
	assign underflow = q.timer_active_flag && tick_bus.tick && (q.count == 16'h0000);

	always_comb begin
		d                 = q;
		st_set            = '0;
		st_clr            = '0;
		d.wake_req        = 1'b0;
		d.trim_start      = 1'b0;
		d.rf_window_start = 1'b0;
		d.power_down_req  = 1'b0;
		d.pready          = 1'b0;
		d.pslverr         = 1'b0;

		// setup phase: prepare answer for the access phase
		if (psel && !penable) begin
			d.pready  = 1'b1;
			d.pslverr = !is_mapped(paddr);
			d.prdata  = 32'h0000_0000;
			unique case (word_index(paddr))
				// running bit read back, permit reads zero
				IDX_CONTROL: d.prdata[7:0] = {q.timer_active_flag, 1'b0,
					q.underflow_trim_enable, q.underflow_card_detect_enable,
					q.reload_on_zero, q.wake_on_underflow, q.tick_source_select};
				IDX_RELOAD_HIGH: d.prdata[7:0] = q.wake_reload_high;
				IDX_RELOAD_LOW:  d.prdata[7:0] = q.wake_reload_low;
				IDX_COUNT_HIGH:  d.prdata[7:0] = q.count[15:8];
				IDX_COUNT_LOW:   d.prdata[7:0] = q.count[7:0];
				IDX_IRQ_STATUS:  d.prdata[ST_WIDTH-1:0] = q.status;
				IDX_IRQ_MASK:    d.prdata[ST_WIDTH-1:0] = q.mask;
				default:         d.prdata = 32'h0000_0000;
			endcase
		end

		// countdown
		if (q.timer_active_flag && tick_bus.tick) begin
			if (q.count == 16'h0000) begin
				if (q.reload_on_zero || q.underflow_card_detect_enable) begin
					d.count = wake_reload_word;
				end else begin
					d.timer_active_flag = 1'b0;
				end
			end else begin
				d.count = q.count - 16'h0001;
			end
		end

		// underflow side effects
		if (underflow) begin
			st_set[ST_UNDERFLOW_BIT] = 1'b1;
			d.wake_req = q.wake_on_underflow;
			d.trim_start = q.underflow_trim_enable;
			if (q.underflow_card_detect_enable && q.card_state == CD_IDLE) begin
				d.rf_window_start = 1'b1;
				d.rf_field_en     = 1'b1;
				d.card_state      = CD_WINDOW;
			end
		end

		// card detection window
		unique case (q.card_state)
			CD_IDLE: begin
			end
			CD_WINDOW: begin
				// field stays on until window ends
				if (rf_window_done) begin
					d.rf_field_en = 1'b0;
					d.card_state  = CD_IDLE;
					if (card_found) begin
						st_set[ST_CARD_BIT] = 1'b1;
					end else begin
						// no card: back to power-down if enabled
						st_set[ST_NOCARD_BIT] = 1'b1;
						d.power_down_req      = q.wake_on_underflow;
					end
				end
			end
		endcase

		// trimming finished: fall back when enabled
		if (trim_done && q.wake_on_underflow) begin
			d.power_down_req = 1'b1;
		end

		// register writes
		if (wr_access) begin
			unique case (word_index(paddr))
				IDX_CONTROL: begin
					d.underflow_trim_enable        = pwdata[CTL_TRIM_BIT];
					d.underflow_card_detect_enable = pwdata[CTL_CARD_BIT];
					d.reload_on_zero               = pwdata[CTL_RELOAD_BIT];
					d.wake_on_underflow            = pwdata[CTL_WAKE_BIT];
					d.tick_source_select           = pwdata[CTL_SEL_LSB +: 2];
					// running bit changes only with permit
					if (pwdata[CTL_PERMIT_BIT]) begin
						d.timer_active_flag = pwdata[CTL_ACTIVE_BIT];
						// start event loads the reload word
						if (pwdata[CTL_ACTIVE_BIT]) begin
							d.count = wake_reload_word;
						end
					end
				end
				// reload bytes only stored, count untouched
				IDX_RELOAD_HIGH: d.wake_reload_high = pwdata[7:0];
				IDX_RELOAD_LOW:  d.wake_reload_low  = pwdata[7:0];
				IDX_IRQ_STATUS:  st_clr = pwdata[ST_WIDTH-1:0];
				IDX_IRQ_MASK:    d.mask = pwdata[ST_WIDTH-1:0];
				default: begin
				end
			endcase
		end

		// sticky status: a set beats a same-cycle clear
		d.status = (q.status & ~st_clr) | st_set;
		d.irq    = |(d.status & d.mask);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q                              <= '0;
			q.timer_active_flag            <= CTL_RESET[CTL_ACTIVE_BIT];
			q.wake_reload_high             <= RELOAD_RESET;
			q.wake_reload_low              <= RELOAD_RESET;
			q.count                        <= COUNT_RESET;
			q.mask                         <= MASK_RESET;
			q.card_state                   <= CD_IDLE;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign prdata          = q.prdata;
	assign pready          = q.pready;
	assign pslverr         = q.pslverr;
	assign irq             = q.irq;
	assign wake_req        = q.wake_req;
	assign trim_start      = q.trim_start;
	assign rf_window_start = q.rf_window_start;
	assign rf_field_en     = q.rf_field_en;
	assign power_down_req  = q.power_down_req;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// underflow that opens a detection window
	sequence s_card_launch;
		underflow && q.underflow_card_detect_enable && q.card_state == CD_IDLE;
	endsequence

	// window closes on the partner's done
	sequence s_window_close;
		q.card_state == CD_WINDOW && rf_window_done;
	endsequence

	a_permit_start_stop: assert property (
		wr_ctl && pwdata[CTL_PERMIT_BIT] |=> q.timer_active_flag == $past(pwdata[CTL_ACTIVE_BIT]))
		else $error("running bit did not follow permitted write");

	a_permit_absent_hold: assert property (
		wr_ctl && !pwdata[CTL_PERMIT_BIT] && !underflow |=> $stable(q.timer_active_flag))
		else $error("running bit changed without permit");

	a_trim_launch: assert property (
		underflow && q.underflow_trim_enable |=> trim_start ##1 !trim_start)
		else $error("trim start not a single pulse after underflow");

	a_card_launch: assert property (
		s_card_launch |=> rf_window_start && rf_field_en ##1 !rf_window_start)
		else $error("card detection not started on underflow");

	a_card_irq: assert property (
		s_window_close and card_found |=> q.status[ST_CARD_BIT] && !power_down_req)
		else $error("card found without interrupt flag");

	a_nocard_sleep: assert property (
		s_window_close and !card_found and q.wake_on_underflow |=> power_down_req)
		else $error("no card but no power-down request");

	a_no_gap: assert property (
		underflow && q.underflow_card_detect_enable && !wr_ctl
		|=> q.timer_active_flag && q.count == $past(wake_reload_word))
		else $error("detection countdown did not restart at once");

	a_field_window: assert property (
		s_card_launch ##1 (!rf_window_done)[*2] |-> rf_field_en)
		else $error("rf field dropped inside window");

	a_one_shot: assert property (
		underflow && !q.reload_on_zero && !q.underflow_card_detect_enable && !wr_ctl
		|=> !q.timer_active_flag)
		else $error("one-shot timer still running after underflow");

	a_flag_set: assert property (
		underflow |=> q.status[ST_UNDERFLOW_BIT] ##1 (irq || !q.mask[ST_UNDERFLOW_BIT]))
		else $error("underflow flag or interrupt missing");

	a_wake_pulse: assert property (
		underflow && q.wake_on_underflow |=> wake_req)
		else $error("no wake request on underflow");

	a_reload_quiet: assert property (
		wr_access && !wr_ctl && !(q.timer_active_flag && tick_bus.tick) |=> $stable(q.count))
		else $error("register write disturbed the countdown");

	a_count_step: assert property (
		q.timer_active_flag && tick_bus.tick && q.count != 16'h0000 && !wr_ctl
		|=> q.count == $past(q.count) - 16'h0001)
		else $error("count did not step by one");

endmodule : wakeup_timer_low_power_card_detect

// *** testbench/tb_wakeup_timer_low_power_card_detect.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_wakeup_timer_low_power_card_detect;
	import wakeup_timer_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        lfo_clk_pin, trim_done, rf_window_done, card_found;
	logic        irq, wake_req, trim_start, rf_window_start, rf_field_en, power_down_req;
	int          err_count, cmp_count, cycles, n_wake, n_trim, n_win, n_pd, s0, s1, s2;
	logic        er;
	// byte addresses of the registers
	localparam logic [11:0] A_CTL = {IDX_CONTROL, 2'b00};
	localparam logic [11:0] A_RH  = {IDX_RELOAD_HIGH, 2'b00};
	localparam logic [11:0] A_RL  = {IDX_RELOAD_LOW, 2'b00};
	localparam logic [11:0] A_CH  = {IDX_COUNT_HIGH, 2'b00};
	localparam logic [11:0] A_CL  = {IDX_COUNT_LOW, 2'b00};
	localparam logic [11:0] A_ST  = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [11:0] A_MK  = {IDX_IRQ_MASK, 2'b00};
	// ------------------------------------------------------------
	// device under test
	// ------------------------------------------------------------
	wakeup_timer_low_power_card_detect dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lfo_clk_pin(lfo_clk_pin), .trim_done(trim_done), .rf_window_done(rf_window_done),
		.card_found(card_found), .irq(irq), .wake_req(wake_req), .trim_start(trim_start),
		.rf_window_start(rf_window_start), .rf_field_en(rf_field_en), .power_down_req(power_down_req));
	// clock generation
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// one-cycle pulse counters and hang guard
	always @(posedge pclk) begin
		n_wake += (wake_req === 1'b1);
		n_trim += (trim_start === 1'b1);
		n_win  += (rf_window_start === 1'b1);
		n_pd   += (power_down_req === 1'b1);
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			final_report();
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait-state limit here: only the cycle ceiling ends a hang
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	// read a register and compare with an expected word
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rd, exp)
	endtask : rchk
	// n oscillator rising edges, each long enough for its tick to land
	task automatic low_freq_oscillator(input int n);
		repeat (n) begin
			@(posedge pclk); lfo_clk_pin <= 1'b1;
			repeat (4) @(posedge pclk);
			lfo_clk_pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask : low_freq_oscillator
	// end of a detection window with the card answer
	task automatic window_end(input logic c);
		@(posedge pclk); card_found <= c; rf_window_done <= 1'b1;
		@(posedge pclk); card_found <= 1'b0; rf_window_done <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : window_end
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// reset values and refused accesses
	task automatic t_reset();
		rchk(A_CTL, 32'h0000_0000);
		rchk(A_CH, 32'h0000_0000);
		rchk(A_CL, 32'h0000_0000);
		rchk(A_MK, 32'h0000_0000);
		apb(1'b1, A_CL, 32'h0000_00A5);
		rchk(A_CL, 32'h0000_0000);
		apb(1'b0, 12'h0A0, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0000_0000})
		apb(1'b0, A_CTL + 12'h001, 32'h0);
		`CHK(er, 1'b1)
	endtask : t_reset
	// run bit changes only together with the permit bit
	task automatic t_permit();
		apb(1'b1, A_RH, 32'h0000_0001);
		apb(1'b1, A_RL, 32'h0000_0002);
		rchk(A_RH, 32'h0000_0001);
		apb(1'b1, A_CTL, 32'h0000_0080);
		rchk(A_CTL, 32'h0000_0000);
		apb(1'b1, A_CTL, 32'h0000_00C8);
		rchk(A_CTL, 32'h0000_0088);
		rchk(A_CH, 32'h0000_0001);
		apb(1'b1, A_CTL, 32'h0000_0040);
		rchk(A_CTL, 32'h0000_0000);
	endtask : t_permit
	// countdown, reload write in flight, underflow with masked interrupt
	task automatic t_count();
		apb(1'b1, A_RH, 32'h0000_0000);
		apb(1'b1, A_CTL, 32'h0000_00CC);
		s0 = n_wake;
		low_freq_oscillator(1);
		rchk(A_CL, 32'h0000_0001);
		apb(1'b1, A_RL, 32'h0000_0005);
		rchk(A_CL, 32'h0000_0001);
		low_freq_oscillator(1);
		rchk(A_CL, 32'h0000_0000);
		`CHK(n_wake, s0)
		low_freq_oscillator(1);
		`CHK(n_wake, s0 + 1)
		rchk(A_CL, 32'h0000_0005);
		rchk(A_CTL, 32'h0000_008C);
		rchk(A_ST, 32'h0000_0001);
		`CHK(irq, 1'b0)
		apb(1'b1, A_MK, 32'h0000_0001);
		// irq is launched by the edge that completes the write
		@(posedge pclk);
		`CHK(irq, 1'b1)
		apb(1'b1, A_ST, 32'h0000_0001);
		@(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b1, A_CTL, 32'h0000_0040);
	endtask : t_count
	// one-shot run stops at zero and clears the running bit
	task automatic t_oneshot();
		apb(1'b1, A_RL, 32'h0000_0001);
		apb(1'b1, A_CTL, 32'h0000_00C0);
		s0 = n_wake;
		low_freq_oscillator(2);
		rchk(A_CTL, 32'h0000_0000);
		low_freq_oscillator(1);
		rchk(A_CL, 32'h0000_0000);
		`CHK(n_wake, s0)
		apb(1'b1, A_ST, 32'h0000_0007);
	endtask : t_oneshot
	// any run of 2n edges holds exactly two ticks when dividing by n
	task automatic t_divider();
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, A_RL, 32'h0000_0040);
			apb(1'b1, A_CTL, 32'h0000_00C8 | s);
			low_freq_oscillator((s == 0) ? 2 : (2 << (s + 2)));
			rchk(A_CL, 32'h0000_003E);
			apb(1'b1, A_CTL, 32'h0000_0040);
		end
	endtask : t_divider
	// card detection with and without a card
	task automatic t_card();
		apb(1'b1, A_RL, 32'h0000_0000);
		apb(1'b1, A_MK, 32'h0000_0007);
		// trimming stays off while detection owns the window timer
		apb(1'b1, A_CTL, 32'h0000_00D4);
		s0 = n_win;
		s1 = n_pd;
		low_freq_oscillator(1);
		`CHK(n_win, s0 + 1)
		`CHK(rf_field_en, 1'b1)
		rchk(A_CTL, 32'h0000_0094);
		window_end(1'b1);
		`CHK(rf_field_en, 1'b0)
		rchk(A_ST, 32'h0000_0003);
		`CHK({irq, n_pd}, {1'b1, s1})
		apb(1'b1, A_ST, 32'h0000_0007);
		low_freq_oscillator(1);
		`CHK(n_win, s0 + 2)
		window_end(1'b0);
		rchk(A_ST, 32'h0000_0005);
		`CHK(n_pd, s1 + 1)
		apb(1'b1, A_ST, 32'h0000_0007);
		apb(1'b1, A_CTL, 32'h0000_0040);
	endtask : t_card
	// trimming launch and fall back to power-down
	task automatic t_trim();
		apb(1'b1, A_CTL, 32'h0000_00E4);
		s0 = n_trim;
		s1 = n_pd;
		s2 = n_wake;
		low_freq_oscillator(1);
		`CHK(n_trim, s0 + 1)
		`CHK(n_wake, s2 + 1)
		rchk(A_CTL, 32'h0000_0024);
		@(posedge pclk); trim_done <= 1'b1;
		@(posedge pclk); trim_done <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK(n_pd, s1 + 1)
		apb(1'b1, A_CTL, 32'h0000_0020);
		@(posedge pclk); trim_done <= 1'b1;
		@(posedge pclk); trim_done <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK(n_pd, s1 + 1)
	endtask : t_trim
	// ------------------------------------------------------------
	// verdict
	// ------------------------------------------------------------
	task automatic final_report();
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, lfo_clk_pin, trim_done, rf_window_done, card_found} = '0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		{err_count, cmp_count, cycles, n_wake, n_trim, n_win, n_pd} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_permit();
		t_count();
		t_oneshot();
		t_divider();
		t_card();
		t_trim();
		final_report();
	end
endmodule : tb_wakeup_timer_low_power_card_detect
